// *** hdl/dme_engine.sv ***
// Signal-processing MAC engine: multiplier, shifter, 40-bit adder,
// two accumulators, saturation, rounding, overflow flags, trap request.
// Assumes the instruction decoder presents one operation per cycle.
//
// Functional notes
// - 17x17 multiplier, barrel shifter, 40-bit adder, two accumulators, round and sat.
// - Engine op and general multiply never run in one cycle; ED uses both.
// - Accumulator add, subtract and negate need no operand beyond accumulators.
// - Clear, ED, SQUARED_DIFF_ACCUM_OP, MAC, square-acc, move, MULTIPLY_OP, square, negated MULTIPLY_OP, MULT_SUBTRACT_OP.
// - Modes: frac/int, sign, rounding, per-acc sat, store sat, sat mode.
// - Multiplier input bit 16 is zero for unsigned, sign for signed.
// - Scaler yields 1.31 fraction or 32-bit integer product.
// - Fractional operands have radix point right after the sign bit.
// - Same multiplier serves general signed, unsigned and mixed multiplies.
// - Byte multiply returns 16 bits, word multiply returns 32 bits.
// - Adder sign extends; selected accumulator is both source and target.
// - Add and load may scale incoming data through the barrel shifter.
// - Optional zero on one side; subtract complements and uses low borrow.
// - Overflow out of bit 39 is catastrophic, sign destroyed.
// - Guard overflow when bits 32 to 39 are not all equal.
// - Saturation uses sum, overflow, per-acc enables and the mode bit.
// - Saturated flag sets on bit 31 or bit 39 saturation.
// - Combined flags are ORs of both overflow and both saturated flags.
// - Guard flags follow every adder pass; flags held in status.
// - Trap request when guard flag and matching trap enable both set.
// - Rounding select 0 gives convergent, 1 gives conventional rounding.
`timescale 1ns/100ps
`include "dme_params.svh"
module dme_engine (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Engine instruction
   input wire logic op_valid,
   input wire dme_pkg::dme_op_t op_code,
   input wire logic acc_sel,
   input wire logic [15:0] x_data,
   input wire logic [15:0] y_data,
   input wire logic [3:0] shift_amt,
   // Core control mode bits
   input wire logic frac_int_select,
   input wire logic mult_sign_control,
   input wire logic rounding_select,
   input wire logic acc_a_sat_enable,
   input wire logic acc_b_sat_enable,
   input wire logic mem_write_sat_enable,
   input wire logic sat_mode_select,
   input wire logic acc_a_trap_enable,
   input wire logic acc_b_trap_enable,
   input wire logic sat_flags_clear,
   // General multiply
   input wire logic mul_valid,
   input wire logic mul_x_unsigned,
   input wire logic mul_y_unsigned,
   input wire logic mul_byte_mode,
   // Accumulator store
   input wire logic store_req,
   input wire logic store_acc_sel,
   input wire logic store_round,
   // Accumulators
   output logic [39:0] accumulator_a_q,
   output logic [39:0] accumulator_b_q,
   // Status
   output logic acc_a_guard_overflow_q,
   output logic acc_b_guard_overflow_q,
   output logic acc_a_saturated_q,
   output logic acc_b_saturated_q,
   output logic any_guard_overflow_q,
   output logic any_saturated_q,
   output logic arith_trap_q,
   // General multiply result
   output logic [31:0] mul_result_q,
   output logic mul_done_q,
   // Store result
   output logic [15:0] store_data_q,
   output logic store_valid_q
);
   import dme_pkg::*;

   // 41-bit add or subtract with optional zero on the first side
   function automatic logic [40:0] dme_add(input logic [39:0] a, input logic [39:0] b,
                                           input logic sub, input logic zero_a);
      logic [40:0] pa;
      logic [40:0] pb;
      pa = zero_a ? 41'h000_0000_0000 : {a[39], a};
      pb = sub ? ~{b[39], b} : {b[39], b};
      // Carry in low on add, borrow low (carry 1) on subtract
      dme_add = pa + pb + {40'h00_0000_0000, sub};
   endfunction : dme_add

   // Positive count shifts right, negative shifts left
   function automatic logic [39:0] dme_shift(input logic [39:0] v, input logic [3:0] amt);
      logic [3:0] left;
      left = 4'(~amt + 4'h1);
      dme_shift = amt[3] ? (v << left) : 40'($signed(v) >>> amt);
   endfunction : dme_shift

   // Rounds bits 15:0 away into bit 16
   function automatic logic [39:0] dme_round(input logic [39:0] v, input logic conv);
      if (!conv && v[15:0] == `DME_RND_HALF) begin
         // Tie goes to even, so repeated rounding does not drift
         dme_round = v + {24'h00_0000, v[16], 15'h0000};
      end else begin
         dme_round = v + {24'h00_0000, `DME_RND_HALF};
      end
   endfunction : dme_round

   logic [15:0] diff;
   logic [15:0] m_x;
   logic [15:0] m_y;
   logic m_xu;
   logic m_yu;
   logic m_frac;
   logic [39:0] prod;
   logic [39:0] acc_cur;
   logic [39:0] acc_oth;
   logic [39:0] shifted;
   logic [39:0] opnd_b;
   logic zero_a;
   logic sub;
   logic pass;
   logic upd;
   logic mul_go;
   logic [40:0] sum;
   logic [39:0] sat_res;
   logic g_ov;
   logic sat_hit;
   logic sat_en;
   logic a_ov_d;
   logic b_ov_d;
   logic a_sat_d;
   logic b_sat_d;
   logic [39:0] st_src;
   logic [39:0] st_rnd;
   logic [15:0] st_d;

   // Squared difference uses the 16-bit subtract in the same cycle
   assign diff = x_data - y_data;
   // Engine owns the multiplier; a general multiply in the same cycle is dropped
   assign mul_go = mul_valid & ~op_valid;

   // Multiplier operand and mode select
   always_comb begin
      m_x = x_data;
      m_y = y_data;
      m_xu = mult_sign_control;
      m_yu = mult_sign_control;
      m_frac = ~frac_int_select;
      if (op_valid) begin
         if (op_code == OP_ED || op_code == OP_SQUARED_DIFF_ACCUM_OP) begin
            m_x = diff;
            m_y = diff;
         end else if (op_code == OP_SQAC || op_code == OP_SQR) begin
            m_y = x_data;
         end
      end else begin
         m_xu = mul_x_unsigned;
         m_yu = mul_y_unsigned;
         m_frac = 1'b0;
         if (mul_byte_mode) begin
            // Byte multiply is unsigned only
            m_x = {8'h00, x_data[7:0]};
            m_y = {8'h00, y_data[7:0]};
            m_xu = 1'b1;
            m_yu = 1'b1;
         end
      end
   end

   dme_mult u_mult (
      .op_x(m_x),
      .op_y(m_y),
      .x_unsigned(m_xu),
      .y_unsigned(m_yu),
      .frac_mode(m_frac),
      .prod(prod)
   );

   assign acc_cur = acc_sel ? accumulator_b_q : accumulator_a_q;
   assign acc_oth = acc_sel ? accumulator_a_q : accumulator_b_q;
   // Incoming word sits in bits 31:16, sign extended
   assign shifted = dme_shift({{8{x_data[15]}}, x_data, 16'h0000}, shift_amt);

   // Operation decode onto the adder
   always_comb begin
      zero_a = 1'b0;
      opnd_b = prod;
      sub = 1'b0;
      pass = 1'b1;
      unique case (op_code)
         OP_CLR: begin
            zero_a = 1'b1;
            opnd_b = `DME_ACC_ZERO;
         end
         OP_ED, OP_MPY, OP_SQR: begin
            zero_a = 1'b1;
         end
         OP_SQUARED_DIFF_ACCUM_OP, OP_MAC, OP_SQAC: begin
            zero_a = 1'b0;
         end
         OP_PREFETCH_MOVE_OP: begin
            pass = 1'b0;
         end
         OP_MPYN: begin
            zero_a = 1'b1;
            sub = 1'b1;
         end
         OP_MSC: begin
            sub = 1'b1;
         end
         OP_ADDAB: begin
            opnd_b = acc_oth;
         end
         OP_SUBAB: begin
            opnd_b = acc_oth;
            sub = 1'b1;
         end
         OP_NEG: begin
            zero_a = 1'b1;
            opnd_b = acc_cur;
            sub = 1'b1;
         end
         OP_ADDSH: begin
            opnd_b = shifted;
         end
         OP_LAC: begin
            zero_a = 1'b1;
            opnd_b = shifted;
         end
         default: begin
            // Illegal code leaves the accumulators alone
            pass = 1'b0;
         end
      endcase
   end

   assign sum = dme_add(acc_cur, opnd_b, sub, zero_a);
   assign sat_en = acc_sel ? acc_b_sat_enable : acc_a_sat_enable;
   assign upd = op_valid & pass;

   dme_sat u_sat (
      .sum(sum),
      .sat_en(sat_en),
      .sat_mode(sat_mode_select),
      .res(sat_res),
      .guard_ov(g_ov),
      .saturated(sat_hit)
   );

   // Accumulators
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         accumulator_a_q <= `DME_ACC_ZERO;
         accumulator_b_q <= `DME_ACC_ZERO;
      end else if (upd) begin
         if (acc_sel) begin
            accumulator_b_q <= sat_res;
         end else begin
            accumulator_a_q <= sat_res;
         end
      end
   end

   // Guard flags track the last pass; saturated flags stick, set beats clear
   assign a_ov_d = (upd & ~acc_sel) ? g_ov : acc_a_guard_overflow_q;
   assign b_ov_d = (upd & acc_sel) ? g_ov : acc_b_guard_overflow_q;
   assign a_sat_d = (upd & ~acc_sel & sat_hit) | (acc_a_saturated_q & ~sat_flags_clear);
   assign b_sat_d = (upd & acc_sel & sat_hit) | (acc_b_saturated_q & ~sat_flags_clear);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_a_guard_overflow_q <= 1'b0;
         acc_b_guard_overflow_q <= 1'b0;
         acc_a_saturated_q <= 1'b0;
         acc_b_saturated_q <= 1'b0;
         any_guard_overflow_q <= 1'b0;
         any_saturated_q <= 1'b0;
      end else begin
         acc_a_guard_overflow_q <= a_ov_d;
         acc_b_guard_overflow_q <= b_ov_d;
         acc_a_saturated_q <= a_sat_d;
         acc_b_saturated_q <= b_sat_d;
         any_guard_overflow_q <= a_ov_d | b_ov_d;
         any_saturated_q <= a_sat_d | b_sat_d;
      end
   end

   // Trap request is a level while flag and enable stand
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         arith_trap_q <= 1'b0;
      end else begin
         arith_trap_q <= (a_ov_d & acc_a_trap_enable) | (b_ov_d & acc_b_trap_enable);
      end
   end

   // General multiply result
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mul_result_q <= 32'h0000_0000;
         mul_done_q <= 1'b0;
      end else begin
         mul_done_q <= mul_go;
         if (mul_go) begin
            mul_result_q <= mul_byte_mode ? {16'h0000, prod[15:0]} : prod[31:0];
         end
      end
   end

   // Store path reads the accumulator as it stood before this cycle
   assign st_src = store_acc_sel ? accumulator_b_q : accumulator_a_q;
   assign st_rnd = store_round ? dme_round(st_src, rounding_select) : st_src;

   always_comb begin
      st_d = st_rnd[31:16];
      if (mem_write_sat_enable && !((&st_rnd[39:31]) || !(|st_rnd[39:31]))) begin
         st_d = st_rnd[39] ? `DME_ST_MIN : `DME_ST_MAX;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         store_data_q <= 16'h0000;
         store_valid_q <= 1'b0;
      end else begin
         store_valid_q <= store_req;
         if (store_req) begin
            store_data_q <= st_d;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_clr_zero: assert property (op_valid && op_code == OP_CLR && !acc_sel
      |=> accumulator_a_q == `DME_ACC_ZERO) else $error("clear did not zero A");
   a_move_hold: assert property (op_valid && op_code == OP_PREFETCH_MOVE_OP
      |=> $stable(accumulator_a_q) && $stable(accumulator_b_q)) else $error("move changed acc");
   a_any_ov_or: assert property (any_guard_overflow_q ==
      (acc_a_guard_overflow_q | acc_b_guard_overflow_q)) else $error("combined ov wrong");
   a_any_sat_or: assert property (any_saturated_q ==
      (acc_a_saturated_q | acc_b_saturated_q)) else $error("combined sat wrong");
   a_trap_cause: assert property (arith_trap_q |->
      (acc_a_guard_overflow_q && $past(acc_a_trap_enable))
      || (acc_b_guard_overflow_q && $past(acc_b_trap_enable))) else $error("trap without cause");
   a_sat_sticky: assert property (acc_a_saturated_q && !sat_flags_clear
      |=> acc_a_saturated_q) else $error("sat flag lost");
   a_clamp_131: assert property (upd && !acc_sel && acc_a_sat_enable && !sat_mode_select
      |=> (&accumulator_a_q[39:31]) || !(|accumulator_a_q[39:31])) else $error("not clamped 1.31");
   a_mul_excl: assert property (op_valid |=> !mul_done_q) else $error("multiply overlapped");
   a_guard_track: assert property (upd && !acc_sel && !acc_a_sat_enable
      |=> acc_a_guard_overflow_q == !((&accumulator_a_q[39:32]) || !(|accumulator_a_q[39:32])))
      else $error("guard flag stale");
   a_mul_word: assert property (mul_go && !mul_byte_mode && !mul_x_unsigned && !mul_y_unsigned
      |=> $signed(mul_result_q) == $signed($past(x_data)) * $signed($past(y_data)))
      else $error("signed multiply wrong");

   c_mac_sat: cover property (upd && op_code == OP_MAC && sat_hit);
   c_trap: cover property (!arith_trap_q ##1 arith_trap_q);
   c_store_clamp: cover property (store_req && mem_write_sat_enable && st_d == `DME_ST_MAX);
endmodule : dme_engine

// *** hdl/dme_mult.sv ***
// 17x17 multiplier with fractional or integer output scaler
// Combinational; the engine top registers whatever it keeps
`timescale 1ns/100ps
module dme_mult (
   // Operands
   input wire logic [15:0] op_x,
   input wire logic [15:0] op_y,
   input wire logic x_unsigned,
   input wire logic y_unsigned,
   input wire logic frac_mode,
   // Product, sign extended to 40 bits
   output logic [39:0] prod
);
   logic signed [16:0] ext_x;
   logic signed [16:0] ext_y;
   logic signed [33:0] p34;

   // Seventeenth bit is zero or the sign
   assign ext_x = {op_x[15] & ~x_unsigned, op_x};
   assign ext_y = {op_y[15] & ~y_unsigned, op_y};
   assign p34 = ext_x * ext_y;
   // Fractional drops the redundant sign bit, radix after sign: 1.31
   assign prod = frac_mode ? {{5{p34[33]}}, p34, 1'b0} : {{6{p34[33]}}, p34};
endmodule : dme_mult

// *** hdl/dme_params.svh ***
// Constants of the signal-processing MAC engine
// Included by the engine files; definitions only
`ifndef DME_PARAMS_SVH
`define DME_PARAMS_SVH
`define DME_ACC_ZERO 40'h00_0000_0000
`define DME_MAX_131 40'h00_7FFF_FFFF
`define DME_MIN_131 40'hFF_8000_0000
`define DME_MAX_931 40'h7F_FFFF_FFFF
`define DME_MIN_931 40'h80_0000_0000
`define DME_ST_MAX 16'h7FFF
`define DME_ST_MIN 16'h8000
`define DME_RND_HALF 16'h8000
`endif

// *** hdl/dme_pkg.sv ***
// Types of the signal-processing MAC engine
// Shared by the engine top and its testbench
package dme_pkg;
   // One-hot operation codes
   typedef enum logic [14:0] {
      OP_CLR    = 15'h0001,
      OP_ED     = 15'h0002,
      OP_SQUARED_DIFF_ACCUM_OP   = 15'h0004,
      OP_MAC    = 15'h0008,
      OP_SQAC   = 15'h0010,
      OP_PREFETCH_MOVE_OP = 15'h0020,
      OP_MPY    = 15'h0040,
      OP_SQR    = 15'h0080,
      OP_MPYN   = 15'h0100,
      OP_MSC    = 15'h0200,
      OP_ADDAB  = 15'h0400,
      OP_SUBAB  = 15'h0800,
      OP_NEG    = 15'h1000,
      OP_ADDSH  = 15'h2000,
      OP_LAC    = 15'h4000
   } dme_op_t;
endpackage : dme_pkg

// *** hdl/dme_sat.sv ***
// Overflow detection and saturation of a 41-bit adder result
// Combinational; the sum arrives sign extended by one bit
`timescale 1ns/100ps
`include "dme_params.svh"
module dme_sat (
   // Adder result and mode
   input wire logic [40:0] sum,
   input wire logic sat_en,
   input wire logic sat_mode,
   // Outcome
   output logic [39:0] res,
   output logic guard_ov,
   output logic saturated
);
   logic cat;
   logic b31_ov;

   // Sign of bit 39 no longer the true sign
   assign cat = sum[40] ^ sum[39];
   assign guard_ov = ~((&sum[39:32]) | ~(|sum[39:32]));
   assign b31_ov = ~((&sum[39:31]) | ~(|sum[39:31]));

   // Bit 40 always holds the true sign
   always_comb begin
      res = sum[39:0];
      saturated = 1'b0;
      if (sat_en) begin
         if (sat_mode) begin
            if (cat) begin
               res = sum[40] ? `DME_MIN_931 : `DME_MAX_931;
               saturated = 1'b1;
            end
         end else if (cat | b31_ov) begin
            res = sum[40] ? `DME_MIN_131 : `DME_MAX_131;
            saturated = 1'b1;
         end
      end
   end
endmodule : dme_sat

// *** verif/dme_core_model.sv ***
// Model of the instruction decoder and register array feeding the engine
// Assumes one caller at a time; drives 1 ns after each rising clock edge
`timescale 1ns/100ps
module dme_core_model (
   // Clock
   input wire logic clk,
   // Engine instruction
   output logic op_valid,
   output dme_pkg::dme_op_t op_code,
   output logic acc_sel,
   output logic [15:0] x_data,
   output logic [15:0] y_data,
   output logic [3:0] shift_amt,
   // Mode bits, trap b down to integer select
   output logic [8:0] mode,
   output logic sat_clr,
   // General multiply: byte, y unsigned, x unsigned
   output logic mul_valid,
   output logic [2:0] mul_cfg,
   // Accumulator store
   output logic store_req,
   output logic store_sel,
   output logic store_rnd
);
   import dme_pkg::*;
   initial begin
      op_valid = 1'b0;
      op_code = OP_CLR;
      acc_sel = 1'b0;
      x_data = 16'h0000;
      y_data = 16'h0000;
      shift_amt = 4'h0;
      mode = 9'h000;
      sat_clr = 1'b0;
      mul_valid = 1'b0;
      mul_cfg = 3'h0;
      store_req = 1'b0;
      store_sel = 1'b0;
      store_rnd = 1'b0;
   end
   task automatic set_mode(input logic [8:0] m);
      @(posedge clk) #1;
      mode = m;
   endtask : set_mode
   // Released operands show the inverse, so a stale copy never matches
   task automatic op(input dme_op_t c, input logic s, input logic [15:0] x,
                     input logic [15:0] y, input logic [3:0] sh);
      @(posedge clk) #1;
      op_valid = 1'b1;
      op_code = c;
      acc_sel = s;
      x_data = x;
      y_data = y;
      shift_amt = sh;
      @(posedge clk) #1;
      op_valid = 1'b0;
      x_data = ~x;
      y_data = ~y;
   endtask : op
   // A clash puts an engine op in the same cycle as the multiply
   task automatic mul(input logic [15:0] x, input logic [15:0] y, input logic [2:0] cfg,
                      input logic clash);
      @(posedge clk) #1;
      mul_valid = 1'b1;
      mul_cfg = cfg;
      op_valid = clash;
      op_code = OP_PREFETCH_MOVE_OP;
      x_data = x;
      y_data = y;
      @(posedge clk) #1;
      mul_valid = 1'b0;
      op_valid = 1'b0;
      x_data = ~x;
      y_data = ~y;
   endtask : mul
   task automatic store(input logic s, input logic r);
      @(posedge clk) #1;
      store_req = 1'b1;
      store_sel = s;
      store_rnd = r;
      @(posedge clk) #1;
      store_req = 1'b0;
   endtask : store
   task automatic clr_sat();
      @(posedge clk) #1;
      sat_clr = 1'b1;
      @(posedge clk) #1;
      sat_clr = 1'b0;
   endtask : clr_sat
endmodule : dme_core_model

// *** verif/tb_dme_engine.sv ***
// Self-checking bench of the MAC engine, one task per scenario
// Assumes the core model drives every engine input except clock and reset
`timescale 1ns/100ps
module tb_dme_engine;
   import dme_pkg::*;
   typedef struct packed {
      dme_op_t c;
      logic [15:0] x;
      logic [15:0] y;
      logic [3:0] sh;
      logic [39:0] e;
   } dme_step_t;
   // Accumulator A walk, integer signed mode, B preloaded with 3
   localparam dme_step_t steps [15] = '{
      '{OP_CLR, 16'h0, 16'h0, 4'h0, 40'h0}, '{OP_MPY, 16'h5, 16'h1, 4'h0, 40'h5},
      '{OP_ADDAB, 16'h0, 16'h0, 4'h0, 40'h8}, '{OP_SUBAB, 16'h0, 16'h0, 4'h0, 40'h5},
      '{OP_NEG, 16'h0, 16'h0, 4'h0, 40'hFF_FFFF_FFFB},
      '{OP_PREFETCH_MOVE_OP, 16'h9, 16'h9, 4'h0, 40'hFF_FFFF_FFFB},
      '{OP_MAC, 16'h2, 16'h3, 4'h0, 40'h1}, '{OP_MSC, 16'h2, 16'h3, 4'h0, 40'hFF_FFFF_FFFB},
      '{OP_MPYN, 16'h3, 16'h4, 4'h0, 40'hFF_FFFF_FFF4}, '{OP_ED, 16'h7, 16'h3, 4'h0, 40'h10},
      '{OP_SQUARED_DIFF_ACCUM_OP, 16'h7, 16'h3, 4'h0, 40'h20}, '{OP_SQR, 16'h5, 16'h0, 4'h0, 40'h19},
      '{OP_SQAC, 16'h5, 16'h0, 4'h0, 40'h32}, '{OP_ADDSH, 16'h1, 16'h0, 4'h4, 40'h1032},
      '{dme_op_t'(15'h0003), 16'h1, 16'h1, 4'h0, 40'h1032}};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic op_valid, acc_sel, sat_clr, mul_valid, store_req, store_sel, store_rnd;
   dme_op_t op_code;
   logic [15:0] x_data, y_data, store_data;
   logic [3:0] shift_amt;
   logic [8:0] mode;
   logic [2:0] mul_cfg;
   logic [39:0] acc_a, acc_b;
   logic [31:0] mul_res;
   logic mul_done, store_valid;
   wire [6:0] flg;
   int n_mismatch = 0;
   int num_checks = 0;
   always #5 clk = ~clk;
   dme_core_model i_core (.clk(clk), .op_valid(op_valid), .op_code(op_code),
      .acc_sel(acc_sel), .x_data(x_data), .y_data(y_data), .shift_amt(shift_amt),
      .mode(mode), .sat_clr(sat_clr), .mul_valid(mul_valid), .mul_cfg(mul_cfg),
      .store_req(store_req), .store_sel(store_sel), .store_rnd(store_rnd));
   dme_engine i_dut (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
      .acc_sel(acc_sel), .x_data(x_data), .y_data(y_data), .shift_amt(shift_amt),
      .frac_int_select(mode[0]), .mult_sign_control(mode[1]), .rounding_select(mode[2]),
      .acc_a_sat_enable(mode[3]), .acc_b_sat_enable(mode[4]),
      .mem_write_sat_enable(mode[5]), .sat_mode_select(mode[6]),
      .acc_a_trap_enable(mode[7]), .acc_b_trap_enable(mode[8]), .sat_flags_clear(sat_clr),
      .mul_valid(mul_valid), .mul_x_unsigned(mul_cfg[0]), .mul_y_unsigned(mul_cfg[1]),
      .mul_byte_mode(mul_cfg[2]), .store_req(store_req), .store_acc_sel(store_sel),
      .store_round(store_rnd), .accumulator_a_q(acc_a), .accumulator_b_q(acc_b),
      .acc_a_guard_overflow_q(flg[6]), .acc_b_guard_overflow_q(flg[5]),
      .acc_a_saturated_q(flg[4]), .acc_b_saturated_q(flg[3]),
      .any_guard_overflow_q(flg[2]), .any_saturated_q(flg[1]), .arith_trap_q(flg[0]),
      .mul_result_q(mul_res), .mul_done_q(mul_done), .store_data_q(store_data),
      .store_valid_q(store_valid));
   task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic t_reset();
      @(posedge clk) #1;
      chk(acc_a | acc_b, 40'h0, "acc rst");
      chk(40'(flg), 40'h0, "flag rst");
   endtask : t_reset
   task automatic t_mult();
      i_core.set_mode(9'h001);
      i_core.op(OP_MPY, 1'b0, 16'h0005, 16'hFFFD, 4'h0);
      chk(acc_a, 40'hFF_FFFF_FFF1, "signed");
      i_core.set_mode(9'h003);
      i_core.op(OP_MPY, 1'b0, 16'hFFFF, 16'h0002, 4'h0);
      chk(acc_a, 40'h00_0001_FFFE, "unsigned");
      i_core.set_mode(9'h000);
      i_core.op(OP_MPY, 1'b0, 16'h4000, 16'h4000, 4'h0);
      chk(acc_a, 40'h00_2000_0000, "frac");
      i_core.op(OP_MPY, 1'b0, 16'h8000, 16'h8000, 4'h0);
      chk(acc_a, 40'h00_8000_0000, "minus one");
   endtask : t_mult
   task automatic t_ops();
      i_core.set_mode(9'h001);
      i_core.op(OP_MPY, 1'b1, 16'h0003, 16'h0001, 4'h0);
      foreach (steps[i]) begin
         i_core.op(steps[i].c, 1'b0, steps[i].x, steps[i].y, steps[i].sh);
         chk(acc_a, steps[i].e, "op walk");
      end
      chk(acc_b, 40'h3, "b kept");
   endtask : t_ops
   // Guard overflow on A with its trap enabled, then on B with trap off
   task automatic t_ovf();
      i_core.set_mode(9'h081);
      i_core.op(OP_LAC, 1'b0, 16'h4000, 16'h0, 4'hE);
      chk(acc_a, 40'h01_0000_0000, "lac");
      chk(40'(flg), 40'h45, "ovf a");
      i_core.op(OP_LAC, 1'b1, 16'h4000, 16'h0, 4'hE);
      chk(40'(flg), 40'h65, "ovf b");
      i_core.op(OP_CLR, 1'b0, 16'h0, 16'h0, 4'h0);
      chk(40'(flg), 40'h24, "clr a");
      i_core.set_mode(9'h101);
      @(posedge clk) #1;
      chk(40'(flg), 40'h25, "trap b");
      i_core.op(OP_CLR, 1'b1, 16'h0, 16'h0, 4'h0);
      chk(40'(flg), 40'h00, "clr b");
   endtask : t_ovf
   task automatic t_sat();
      i_core.set_mode(9'h009);
      i_core.op(OP_LAC, 1'b0, 16'h4000, 16'h0, 4'hE);
      chk(acc_a, 40'h00_7FFF_FFFF, "sat pos");
      chk(40'({flg[4], flg[1]}), 40'h3, "sat flag");
      i_core.op(OP_LAC, 1'b0, 16'hC000, 16'h0, 4'hE);
      chk(acc_a, 40'hFF_8000_0000, "sat neg");
      i_core.clr_sat();
      i_core.set_mode(9'h059);
      i_core.op(OP_LAC, 1'b0, 16'h4000, 16'h0, 4'hE);
      chk(acc_a, 40'h01_0000_0000, "no sat 931");
      chk(40'({flg[4], flg[1]}), 40'h0, "sat clr");
      i_core.op(OP_LAC, 1'b0, 16'h7FFF, 16'h0, 4'h8);
      i_core.op(OP_LAC, 1'b1, 16'h7FFF, 16'h0, 4'h8);
      i_core.op(OP_ADDAB, 1'b0, 16'h0, 16'h0, 4'h0);
      chk(acc_a, 40'h7F_FFFF_FFFF, "bit39 sat");
      chk(40'({flg[4], flg[1]}), 40'h3, "sat39 flag");
      i_core.op(OP_ADDAB, 1'b1, 16'h0, 16'h0, 4'h0);
      chk(acc_b, 40'h7F_FFFF_FFFF, "b sat");
      chk(40'(flg[3]), 40'h1, "b sat flag");
      i_core.clr_sat();
   endtask : t_sat
   task automatic t_store();
      i_core.set_mode(9'h001);
      i_core.op(OP_MPY, 1'b0, 16'h0080, 16'h0100, 4'h0);
      i_core.store(1'b0, 1'b1);
      chk(40'(store_data), 40'h0000, "convergent");
      chk(40'(store_valid), 40'h1, "st pulse");
      @(posedge clk) #1;
      chk(40'(store_valid), 40'h0, "st end");
      i_core.set_mode(9'h005);
      i_core.store(1'b0, 1'b1);
      chk(40'(store_data), 40'h0001, "conventional");
      i_core.op(OP_MPY, 1'b0, 16'h0180, 16'h0100, 4'h0);
      i_core.set_mode(9'h001);
      i_core.store(1'b0, 1'b1);
      chk(40'(store_data), 40'h0002, "to even");
      i_core.op(OP_LAC, 1'b0, 16'h4000, 16'h0, 4'hE);
      i_core.store(1'b0, 1'b0);
      chk(40'(store_data), 40'h0000, "no clamp");
      i_core.set_mode(9'h021);
      i_core.store(1'b0, 1'b0);
      chk(40'(store_data), 40'h7FFF, "clamp");
      i_core.set_mode(9'h001);
      i_core.store(1'b1, 1'b0);
      chk(40'(store_data), 40'hFFFF, "store b");
   endtask : t_store
   task automatic t_gmul();
      i_core.mul(16'hFFFF, 16'h0003, 3'h0, 1'b0);
      chk(40'({mul_done, mul_res}), 40'h1_FFFF_FFFD, "mul s");
      i_core.mul(16'hFFFF, 16'h0003, 3'h1, 1'b0);
      chk(40'({mul_done, mul_res}), 40'h1_0002_FFFD, "mul us");
      i_core.mul(16'hFFFF, 16'h8000, 3'h2, 1'b0);
      chk(40'({mul_done, mul_res}), 40'h1_FFFF_8000, "mul su");
      i_core.mul(16'h12FF, 16'h34FF, 3'h4, 1'b0);
      chk(40'({mul_done, mul_res}), 40'h1_0000_FE01, "mul byte");
      i_core.mul(16'h0002, 16'h0002, 3'h0, 1'b1);
      chk(40'({mul_done, mul_res}), 40'h0_0000_FE01, "mul clash");
   endtask : t_gmul
   task automatic wrap_up();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   // Whole run needs well under a thousand cycles
   initial begin
      #100us;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      t_reset();
      t_mult();
      t_ops();
      t_ovf();
      t_sat();
      t_store();
      t_gmul();
      wrap_up();
   end
endmodule : tb_dme_engine
